// file: verilog/fdp_pkg.sv
// Shared constants and carriers for the front-side bus data phase.
// Assumes one core clock and one link clock; no software registers.
package fdp_pkg;
    localparam int DATA_W      = 64;
    localparam int GROUPS      = 4;
    localparam int GROUP_W     = 16;
    localparam int HALF_GROUP  = 8;
    localparam int BEATS       = 4;
    localparam int FIFO_DEPTH  = 8;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              last;
    } fdp_word_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [GROUPS-1:0] inv;
        logic [GROUPS-1:0] par;
    } fdp_bus_word_t;

    typedef enum logic [3:0] {
        FDP_IDLE = 4'h1,
        FDP_BUSY = 4'h2,
        FDP_XFER = 4'h4,
        FDP_DONE = 4'h8
    } fdp_state_t;
endpackage

// file: verilog/fdp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low synchronous reset.
module fdp_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: verilog/fdp_data_phase.sv
// Data-phase driver and receiver for the front-side bus.
// Assumes link_clk is the common bus clock; strobes arrive as inputs.
// How it works
// - Busy held asserted by us while our transfer uses the data bus.
// - Four parity lines, one per 16-bit group, cover the data.
// - Parity driven with the data, by the same driver, same time.
// - Data-valid asserted for every word we put on the bus.
// - Valid dropped for idle clocks; receiver ignores bus then.
// - Received data latched on falling edges of both negative and positive strobes of the driver.
// - Group inverted, flag set, when over half its bits go low.
// - At most one word per link clock; both strobe falling edges latch data.
module fdp_data_phase
    import fdp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              link_clk,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_last,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    output logic                   completion_a_seen,
    input  wire logic [DATA_W-1:0] bus_data_in,
    output logic [DATA_W-1:0]      bus_data_out,
    output logic                   bus_data_oe,
    input  wire logic [GROUPS-1:0] group_inversion_flags_in,
    output logic [GROUPS-1:0]      group_inversion_flags_out,
    input  wire logic [GROUPS-1:0] data_parity_lines_in,
    output logic [GROUPS-1:0]      data_parity_lines_out,
    input  wire logic              data_bus_in_use_in,
    output logic                   data_bus_in_use_out,
    output logic                   data_bus_in_use_oe,
    input  wire logic              data_transfer_valid_in,
    output logic                   data_transfer_valid_out,
    output logic                   data_transfer_valid_oe,
    input  wire logic              completion_a,
    input  wire logic [GROUPS-1:0] neg_data_strobes,
    input  wire logic [GROUPS-1:0] pos_data_strobes,
    output logic                   parity_error
);
    fdp_word_t     f_in;
    fdp_word_t     f_out;
    logic          f_valid;
    logic          f_ready;
    fdp_state_t    state;
    fdp_bus_word_t enc;
    logic [SYNC_STAGES-1:0] busy_sync;
    logic [SYNC_STAGES-1:0] completion_a_sync;
    logic [SYNC_STAGES-1:0] rx_tog_sync;
    logic [GROUPS-1:0] nstb_q;
    logic [GROUPS-1:0] pstb_q;
    logic          rx_tog;
    logic          rx_tog_seen;
    logic [DATA_W-1:0] rx_hold;
    logic [DATA_W-1:0] rx_cap;
    logic          rx_cap_ok;
    logic          rx_edge;

    // Inversion decision: more than half the bits electrically low
    function automatic logic group_wants_inv(logic [GROUP_W-1:0] g);
        logic [$clog2(GROUP_W):0] ones;
        ones = '0;
        for (int i = 0; i < GROUP_W; i++)
            ones = ones + ($clog2(GROUP_W)+1)'(g[i]);
        return ones > ($clog2(GROUP_W)+1)'(HALF_GROUP);
    endfunction

    assign f_in.data = tx_data;
    assign f_in.last = tx_last;

    fdp_fifo #(
        .WIDTH ($bits(fdp_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (link_clk),
        .rst_n     (rst_n),
        .in_data   (f_in),
        .in_valid  (tx_valid),
        .in_ready  (f_ready),
        .out_data  (f_out),
        .out_valid (f_valid),
        .out_ready (state == FDP_XFER)
    );

    // Asserted data (active-low wires) count as ones here
    generate
        for (genvar g = 0; g < GROUPS; g++)
        begin : gen_enc
            assign enc.inv[g] =
                group_wants_inv(f_out.data[g*GROUP_W +: GROUP_W]);
            assign enc.data[g*GROUP_W +: GROUP_W] = enc.inv[g]
                ? ~f_out.data[g*GROUP_W +: GROUP_W]
                : f_out.data[g*GROUP_W +: GROUP_W];
            assign enc.par[g] =
                ^{enc.data[g*GROUP_W +: GROUP_W], enc.inv[g]};
        end
    endgenerate

    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
        begin
            busy_sync  <= '0;
            completion_a_sync <= '0;
        end
        else
        begin
            busy_sync  <= {busy_sync[0], data_bus_in_use_in};
            completion_a_sync <= {completion_a_sync[0], completion_a};
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
            tx_ready <= 1'b0;
        else
            tx_ready <= f_ready;
    end

    // Transmit sequencer on the link clock
    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
            state <= FDP_IDLE;
        else
            case (state)
                FDP_IDLE: if (f_valid && !busy_sync[1])
                              state <= FDP_BUSY;
                FDP_BUSY: state <= FDP_XFER;
                FDP_XFER: if (f_valid && f_out.last)
                              state <= FDP_DONE;
                FDP_DONE: state <= FDP_IDLE;
                default:  state <= FDP_IDLE;
            endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
        begin
            data_bus_in_use_out      <= 1'b0;
            data_bus_in_use_oe       <= 1'b0;
            data_transfer_valid_out  <= 1'b0;
            data_transfer_valid_oe   <= 1'b0;
            bus_data_out             <= '0;
            bus_data_oe              <= 1'b0;
            group_inversion_flags_out <= '0;
            data_parity_lines_out    <= '0;
        end
        else
        begin
            // busy while we own the bus
            // Held through the last word, dropped in DONE
            data_bus_in_use_out <= (state == FDP_BUSY)
                                 || (state == FDP_XFER);
            data_bus_in_use_oe  <= (state != FDP_IDLE);
            data_transfer_valid_out <= (state == FDP_XFER) && f_valid;
            data_transfer_valid_oe  <= (state == FDP_XFER)
                                     || (state == FDP_BUSY);
            bus_data_oe <= (state == FDP_XFER);
            if (state == FDP_XFER && f_valid)
            begin
                bus_data_out              <= enc.data;
                group_inversion_flags_out <= enc.inv;
                data_parity_lines_out     <= enc.par;
            end
        end
    end

    // latch on strobe falling edges; strobes registered once, compared with live value
    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
        begin
            nstb_q <= '0;
            pstb_q <= '0;
        end
        else
        begin
            nstb_q <= neg_data_strobes;
            pstb_q <= pos_data_strobes;
        end
    end

    assign rx_edge = |((nstb_q & ~neg_data_strobes)
                     | (pstb_q & ~pos_data_strobes));

    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
        begin
            rx_hold      <= '0;
            rx_tog       <= 1'b0;
            parity_error <= 1'b0;
        end
        else if (rx_edge && data_transfer_valid_in && !bus_data_oe)
        begin
            for (int g = 0; g < GROUPS; g++)
                rx_hold[g*GROUP_W +: GROUP_W] <=
                    group_inversion_flags_in[g]
                    ? ~bus_data_in[g*GROUP_W +: GROUP_W]
                    : bus_data_in[g*GROUP_W +: GROUP_W];
            rx_tog <= ~rx_tog;
            for (int g = 0; g < GROUPS; g++)
                if (^{bus_data_in[g*GROUP_W +: GROUP_W],
                      group_inversion_flags_in[g]}
                    != data_parity_lines_in[g])
                    parity_error <= 1'b1;
        end
    end

    // Core-clock side: toggle crossing, held word stable meanwhile
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rx_tog_sync <= '0;
            rx_tog_seen <= 1'b0;
            rx_data     <= '0;
            rx_valid    <= 1'b0;
            rx_cap      <= '0;
            rx_cap_ok   <= 1'b0;
        end
        else
        begin
            rx_tog_sync <= {rx_tog_sync[0], rx_tog};
            rx_tog_seen <= rx_tog_sync[1];
            rx_cap_ok   <= rx_tog_sync[1] != rx_tog_seen;
            rx_cap      <= rx_hold;
            rx_valid    <= rx_cap_ok;
            if (rx_cap_ok)
                rx_data <= rx_cap;
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
            completion_a_seen <= 1'b0;
        else
            completion_a_seen <= completion_a_sync[1];
    end
endmodule

// file: tb/fdp_props.sv
// Checker on the block's bus-side handshake pins.
// Bound into fdp_data_phase; bus pins live on link_clk.
module fdp_props
    import fdp_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic bus_data_oe,
    input wire logic data_bus_in_use_in,
    input wire logic data_bus_in_use_out,
    input wire logic data_bus_in_use_oe,
    input wire logic data_transfer_valid_out,
    input wire logic data_transfer_valid_oe,
    input wire logic completion_a,
    input wire logic completion_a_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    wire v  = data_transfer_valid_out;
    wire bo = data_bus_in_use_out;
    default clocking @(posedge link_clk);
    endclocking
    default disable iff (!rst_n);
    a_valid_in_busy: assert property (v |-> bo)
        else $error("valid outside busy");
    a_busy_pin_driven: assert property (bo |-> data_bus_in_use_oe)
        else $error("busy not driven");
    a_parity_with_data: assert property (v |-> bus_data_oe)
        else $error("data lines not driven with valid");
    a_valid_pin_driven: assert property (v |-> data_transfer_valid_oe)
        else $error("valid not driven");
    a_busy_then_valid: assert property ($rose(bo) |=> v)
        else $error("no word after busy");
    a_busy_ends_word: assert property ($fell(bo) |-> $past(v))
        else $error("busy dropped without word");
    a_release_gap: assert property ($fell(bo) |-> !bo [*2])
        else $error("bus retaken too soon");
    a_yield_to_owner: assert property (
        data_bus_in_use_in [*4] |=> !$rose(bo))
        else $error("bus taken while owned");
    a_completion_a_noticed: assert property (
        $rose(completion_a) |-> ##[1:5] completion_a_seen)
        else $error("completion_a not reported");
endmodule
bind fdp_data_phase fdp_props fdp_props_i (
    .link_clk                (link_clk),
    .rst_n                   (rst_n),
    .bus_data_oe             (bus_data_oe),
    .data_bus_in_use_in      (data_bus_in_use_in),
    .data_bus_in_use_out     (data_bus_in_use_out),
    .data_bus_in_use_oe      (data_bus_in_use_oe),
    .data_transfer_valid_out (data_transfer_valid_out),
    .data_transfer_valid_oe  (data_transfer_valid_oe),
    .completion_a            (completion_a),
    .completion_a_seen              (completion_a_seen)
);

// file: tb/fdp_agent.sv
// Far-side bus agent: sends one word per transfer to the block.
// Assumes the bench resolves wired lines from both parties.
module fdp_agent
    import fdp_pkg::*;
(
    input  wire logic         link_clk,
    output logic [DATA_W-1:0] ag_d,
    output logic [GROUPS-1:0] ag_inv,
    output logic [GROUPS-1:0] ag_par,
    output logic              ag_busy,
    output logic              ag_val,
    output logic [GROUPS-1:0] neg_data_strobes,
    output logic [GROUPS-1:0] pos_data_strobes
);
    timeunit 1ns;
    timeprecision 100ps;
    function automatic fdp_bus_word_t enc(input logic [DATA_W-1:0] raw);
        logic [GROUP_W-1:0] grp;
        for (int g = 0; g < GROUPS; g++)
        begin
            grp = raw[g*GROUP_W+:GROUP_W];
            enc.inv[g] = $countones(grp) > HALF_GROUP;
            enc.data[g*GROUP_W+:GROUP_W] = enc.inv[g] ? ~grp : grp;
            enc.par[g] = ^enc.data[g*GROUP_W+:GROUP_W] ^ enc.inv[g];
        end
    endfunction
    initial
        {ag_d, ag_inv, ag_par, ag_busy, ag_val, neg_data_strobes,
            pos_data_strobes} = {74'h0, 8'hff};
    task automatic stall(input logic on);
        @(posedge link_clk);
        ag_busy <= on;
    endtask
    task automatic send(input fdp_bus_word_t w, input logic bad,
                        input logic val);
        @(posedge link_clk);
        // busy, valid, data and parity together
        // val low: strobes still fall, word must be ignored
        {ag_busy, ag_val} <= {1'b1, val};
        {ag_d, ag_inv, ag_par} <= w ^ {71'h0, bad};
        @(posedge link_clk);
        {neg_data_strobes, pos_data_strobes} <= 8'h00;
        @(posedge link_clk);
        {ag_busy, ag_val} <= 2'b00;
        {ag_d, ag_inv, ag_par} <= ~w;
        {neg_data_strobes, pos_data_strobes} <= 8'hff;
    endtask
endmodule

// file: tb/tb.sv
// Bench: burst, stalled fill, receive, completion_a, bad parity.
// Assumes fdp_agent on the far side and fdp_props bound.
module tb
    import fdp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              ref_clk = 1'b0;
    logic              link_clk = 1'b0;
    logic              rst_n, tx_last, tx_valid, tx_ready, rx_valid;
    logic              completion_a_seen, bus_data_oe, completion_a, parity_error;
    logic              data_bus_in_use_in, data_bus_in_use_out, ag_busy;
    logic              data_bus_in_use_oe, data_transfer_valid_in, ag_val;
    logic              data_transfer_valid_out, data_transfer_valid_oe;
    logic [DATA_W-1:0] tx_data, rx_data, bus_data_in, bus_data_out, ag_d;
    logic [GROUPS-1:0] group_inversion_flags_in, group_inversion_flags_out;
    logic [GROUPS-1:0] data_parity_lines_in, data_parity_lines_out, ag_inv;
    logic [GROUPS-1:0] ag_par, neg_data_strobes, pos_data_strobes;
    logic [DATA_W-1:0] rx_last;
    fdp_bus_word_t     seen[$];
    int                mismatches, tests_run, rx_cnt, t;
    // Wired lines: driver wins, busy and valid wire-ORed
    assign bus_data_in = bus_data_oe ? bus_data_out : ag_d;
    assign group_inversion_flags_in = bus_data_oe ?
        group_inversion_flags_out : ag_inv;
    assign data_parity_lines_in = bus_data_oe ? data_parity_lines_out : ag_par;
    assign data_bus_in_use_in = ag_busy |
        (data_bus_in_use_oe & data_bus_in_use_out);
    assign data_transfer_valid_in = ag_val |
        (data_transfer_valid_oe & data_transfer_valid_out);
    fdp_data_phase fdp_data_phase_i (.*);
    fdp_agent      fdp_agent_i (.*);
    initial forever #4 ref_clk = ~ref_clk;
    initial #1.3 forever #62.5 link_clk = ~link_clk;
    always @(posedge link_clk)
        if (data_transfer_valid_out === 1'b1)
            seen.push_back({bus_data_out, group_inversion_flags_out,
                data_parity_lines_out});
    always @(posedge ref_clk)
        if (rx_valid === 1'b1)
            {rx_cnt, rx_last} <= {rx_cnt + 1, rx_data};
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_for(input bit rx, input int n);
        for (t = 0; t < 8000 && (rx ? rx_cnt : seen.size()) < n; t++)
            @(posedge ref_clk);
        if (t == 8000)
        begin
            mismatches++;
            stop_test();
        end
    endtask
    task automatic sc_burst;
        logic [DATA_W-1:0] w [3];
        w = '{64'hffff_ffff_ffff_ffff, 64'h0000_01ff_00ff_0000, 64'h0};
        for (int i = 0; i < 3; i++)
        begin
            {tx_data, tx_last, tx_valid} <= {w[i], i == 2, 1'b1};
            @(posedge link_clk);
            if (i == 1)
            begin
                // Starved FIFO: idle clocks inside one transfer
                tx_valid <= 1'b0;
                repeat (6) @(posedge link_clk);
                chk(72'(data_bus_in_use_out), 72'h1);
                chk(72'(data_transfer_valid_out), 72'h0);
            end
        end
        tx_valid <= 1'b0;
        wait_for(1'b0, 3);
        for (int i = 0; i < 3; i++)
            chk(seen.pop_front(), fdp_agent_i.enc(w[i]));
    endtask
    task automatic sc_fill;
        fdp_agent_i.stall(1'b1);
        repeat (4) @(posedge link_clk);
        for (int i = 0; i < 12; i++)
        begin
            {tx_data, tx_last, tx_valid} <= {64'(i), 1'b1, tx_ready};
            @(posedge link_clk);
        end
        tx_valid <= 1'b0;
        chk(72'(tx_ready), 72'h0);
        chk(72'(data_bus_in_use_out), 72'h0);
        fdp_agent_i.stall(1'b0);
        wait_for(1'b0, FIFO_DEPTH);
        for (int i = 0; i < FIFO_DEPTH; i++)
            chk(seen.pop_front(), fdp_agent_i.enc(64'(i)));
        repeat (30) @(posedge link_clk);
    endtask
    task automatic sc_rx;
        fdp_agent_i.send(fdp_agent_i.enc(64'hfff0_0001_8000_7fff),
            1'b0, 1'b1);
        wait_for(1'b1, 1);
        chk(72'(rx_last), 72'hfff0_0001_8000_7fff);
        // Strobes fall while valid is low: word and parity ignored
        fdp_agent_i.send(fdp_agent_i.enc(64'h1234), 1'b1, 1'b0);
        repeat (20) @(posedge link_clk);
        chk(72'(rx_cnt), 72'h1);
        chk(72'(parity_error), 72'h0);
        completion_a <= 1'b1;
        repeat (6) @(posedge link_clk);
        chk(72'(completion_a_seen), 72'h1);
        completion_a <= 1'b0;
        fdp_agent_i.send(fdp_agent_i.enc(64'h0), 1'b1, 1'b1);
        repeat (20) @(posedge link_clk);
        chk(72'({parity_error, completion_a_seen}), 72'h2);
    endtask
    initial
    begin
        {rst_n, tx_data, tx_last, tx_valid, completion_a} = '0;
        repeat (3) @(posedge link_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge link_clk);
        sc_burst();
        sc_fill();
        sc_rx();
        stop_test();
    end
endmodule
